/* lps_top.sv */
// Behaviour
// - 8 bpp: the low byte of the pixel word is one pixel indexing all 256 table entries.
// - each table entry holds six bits per primary colour.
// - 16 bpp: table bypassed, output independent of table contents.
// - no internal clock is gated; the lcd_pclk output is held low when unused.
// - enable bit 0 set enters power save, clear returns to normal.
// - in power save the panel is not driven, display inactive.
// - in power save every lcd output is low.
// - in power save display memory refused, control registers usable.
// - in power save look-up table registers stay accessible.
// - status bit 3 read-only: 1 sram interface down, 0 active.
// - status bit reads 0 after reset.
module lps_top
   import lps_pkg::*;
#(
   parameter int HACT = H_ACTIVE,
   parameter int HTOT = H_TOTAL,
   parameter int VACT = V_ACTIVE,
   parameter int VTOT = V_TOTAL
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic lcd_pclk,
   output logic lcd_hsync,
   output logic lcd_vsync,
   output logic lcd_de,
   output logic [17:0] lcd_data
);
   lps_int_if ib();

   lps_pwr_seq u_seq (
      .clk(clk),
      .resetn(resetn),
      .sb(ib.seq)
   );

   lps_lut_mem #(.DEPTH(LUT_ENTRIES)) u_lut (
      .clk(clk),
      .resetn(resetn),
      .lb(ib.lut)
   );

   // ****************************************
   // control state
   // ****************************************
   logic psave_en_q, psave_en_d;
   logic depth16_q, depth16_d;
   logic blank_q, blank_d;
   logic [LUT_IDX_W-1:0] lut_idx_q, lut_idx_d;
   logic [15:0] pix_word_q, pix_word_d;
   logic lut_we_q, lut_we_d;
   logic [LUT_W-1:0] lut_wdata_q, lut_wdata_d;
   logic [LUT_IDX_W-1:0] lut_waddr_q, lut_waddr_d;
   logic mem_block;

   assign mem_block = psave_en_q | ib.lcd_off;
   assign ib.psave_en = psave_en_q;
   assign ib.lut_we = lut_we_q;
   assign ib.lut_waddr = lut_waddr_q;
   assign ib.lut_wdata = lut_wdata_q;
   assign ib.lut_haddr = lut_idx_q;
   assign ib.lut_paddr = pix_word_q[LUT_IDX_W-1:0];

   // ****************************************
   // axi4-lite write channel
   // ****************************************
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [11:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic wr_mem_q, wr_mem_d, wr_lut_q, wr_lut_d;
   lps_sel_t wsel;
   logic [31:0] wv;

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      wr_mem_d = wr_mem_q;
      wr_lut_d = wr_lut_q;
      psave_en_d = psave_en_q;
      depth16_d = depth16_q;
      blank_d = blank_q;
      lut_idx_d = lut_idx_q;
      pix_word_d = pix_word_q;
      lut_we_d = 1'b0;
      lut_waddr_d = lut_waddr_q;
      lut_wdata_d = lut_wdata_q;
      wsel = lps_decode(aw_addr_q);
      wv = '0;
      if (s_axi_awvalid && awready_q) begin
         aw_have_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_have_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
      if (aw_have_q && w_have_q && !bvalid_q) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = RESP_OKAY;
         wr_mem_d = (wsel == LPS_SEL_MEM);
         wr_lut_d = (wsel == LPS_SEL_LDATA) || (wsel == LPS_SEL_LIDX);
         unique case (wsel)
            LPS_SEL_PSAVE: begin
               // status bits are read-only, only the enable is stored
               wv = lps_merge({31'h0000_0000, psave_en_q}, w_data_q, w_strb_q);
               psave_en_d = wv[PSAVE_EN_BIT];
            end
            LPS_SEL_DISP: begin
               wv = lps_merge({30'h0000_0000, blank_q, depth16_q}, w_data_q, w_strb_q);
               depth16_d = wv[DEPTH16_BIT];
               blank_d = wv[BLANK_BIT];
            end
            LPS_SEL_LIDX: begin
               wv = lps_merge({24'h00_0000, lut_idx_q}, w_data_q, w_strb_q);
               lut_idx_d = wv[LUT_IDX_W-1:0];
            end
            LPS_SEL_LDATA: begin
               wv = lps_merge({14'h0000, ib.lut_hdata}, w_data_q, w_strb_q);
               lut_we_d = 1'b1;
               lut_waddr_d = lut_idx_q;
               lut_wdata_d = wv[LUT_W-1:0];
            end
            LPS_SEL_MEM: begin
               if (mem_block) begin
                  bresp_d = RESP_SLVERR;
               end else begin
                  wv = lps_merge({16'h0000, pix_word_q}, w_data_q, w_strb_q);
                  pix_word_d = wv[15:0];
               end
            end
            LPS_SEL_NONE: bresp_d = RESP_DECERR;
         endcase
      end
      awready_d = !aw_have_d && !bvalid_d;
      wready_d = !w_have_d && !bvalid_d;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         wr_mem_q <= 1'b0;
         wr_lut_q <= 1'b0;
         psave_en_q <= PSAVE_EN_RST;
         depth16_q <= DEPTH16_RST;
         blank_q <= BLANK_RST;
         lut_idx_q <= '0;
         pix_word_q <= '0;
         lut_we_q <= 1'b0;
         lut_waddr_q <= '0;
         lut_wdata_q <= '0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         wr_mem_q <= wr_mem_d;
         wr_lut_q <= wr_lut_d;
         psave_en_q <= psave_en_d;
         depth16_q <= depth16_d;
         blank_q <= blank_d;
         lut_idx_q <= lut_idx_d;
         pix_word_q <= pix_word_d;
         lut_we_q <= lut_we_d;
         lut_waddr_q <= lut_waddr_d;
         lut_wdata_q <= lut_wdata_d;
      end
   end

   // ****************************************
   // axi4-lite read channel
   // ****************************************
   logic rd_pend_q, rd_pend_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [11:0] ar_addr_q, ar_addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic vblank_q, vblank_d;
   lps_sel_t rsel;

   always_comb begin
      rd_pend_d = rd_pend_q;
      ar_addr_d = ar_addr_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      rsel = lps_decode(ar_addr_q);
      if (s_axi_arvalid && arready_q) begin
         rd_pend_d = 1'b1;
         ar_addr_d = s_axi_araddr;
      end
      if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
      if (rd_pend_q) begin
         rd_pend_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = '0;
         unique case (rsel)
            LPS_SEL_PSAVE: begin
               rdata_d[PSAVE_EN_BIT] = psave_en_q;
               rdata_d[MEM_PD_BIT] = ib.mem_pd;
               rdata_d[VBLANK_BIT] = vblank_q;
            end
            LPS_SEL_DISP: rdata_d[1:0] = {blank_q, depth16_q};
            LPS_SEL_LIDX: rdata_d[LUT_IDX_W-1:0] = lut_idx_q;
            LPS_SEL_LDATA: rdata_d[LUT_W-1:0] = ib.lut_hdata;
            LPS_SEL_MEM: begin
               if (mem_block) rresp_d = RESP_SLVERR;
               else rdata_d[15:0] = pix_word_q;
            end
            LPS_SEL_NONE: rresp_d = RESP_DECERR;
         endcase
      end
      arready_d = !rd_pend_d && !rvalid_d;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_pend_q <= 1'b0;
         ar_addr_q <= '0;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else begin
         rd_pend_q <= rd_pend_d;
         ar_addr_q <= ar_addr_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ****************************************
   // pixel timing and output
   // ****************************************
   logic pix_run, force_low, adv, in_act;
   logic pclk_q, pclk_d, hs_q, hs_d, vs_q, vs_d, de_q, de_d;
   logic [15:0] hcnt_q, hcnt_d, vcnt_q, vcnt_d;
   logic [LUT_W-1:0] data_q, data_d;

   assign force_low = psave_en_q | ib.lcd_off;
   assign pix_run = !force_low && !blank_q;
   assign adv = pix_run && pclk_q;
   assign in_act = (hcnt_q < 16'(HACT)) && (vcnt_q < 16'(VACT));

   always_comb begin
      pclk_d = pix_run ? !pclk_q : 1'b0;
      hcnt_d = hcnt_q;
      vcnt_d = vcnt_q;
      hs_d = hs_q;
      vs_d = vs_q;
      de_d = de_q;
      data_d = data_q;
      vblank_d = (vcnt_q >= 16'(VACT));
      if (adv) begin
         if (hcnt_q == 16'(HTOT - 1)) begin
            hcnt_d = '0;
            vcnt_d = (vcnt_q == 16'(VTOT - 1)) ? '0 : vcnt_q + 1'b1;
         end else begin
            hcnt_d = hcnt_q + 1'b1;
         end
         hs_d = (hcnt_q == 16'(HTOT - 1));
         vs_d = (vcnt_q == 16'(VTOT - 1));
         de_d = in_act;
         if (!in_act) data_d = '0;
         else if (depth16_q) data_d = lps_expand565(pix_word_q);
         else data_d = ib.lut_pdata;
      end
      if (force_low) begin
         hcnt_d = '0;
         vcnt_d = '0;
         hs_d = 1'b0;
         vs_d = 1'b0;
         de_d = 1'b0;
         data_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pclk_q <= 1'b0;
         hcnt_q <= '0;
         vcnt_q <= '0;
         hs_q <= 1'b0;
         vs_q <= 1'b0;
         de_q <= 1'b0;
         data_q <= '0;
         vblank_q <= 1'b0;
      end else begin
         pclk_q <= pclk_d;
         hcnt_q <= hcnt_d;
         vcnt_q <= vcnt_d;
         hs_q <= hs_d;
         vs_q <= vs_d;
         de_q <= de_d;
         data_q <= data_d;
         vblank_q <= vblank_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign lcd_pclk = pclk_q;
   assign lcd_hsync = hs_q;
   assign lcd_vsync = vs_q;
   assign lcd_de = de_q;
   assign lcd_data = data_q;

   // ****************************************
   // checks
   // ****************************************
   enter_psave_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(psave_en_q) |-> ##[1:8] ib.mem_pd)
      else $error("sram interface did not power down");
   leave_psave_a: assert property (@(posedge clk) disable iff (!resetn)
      $fell(psave_en_q) |-> ##[1:8] !ib.lcd_off)
      else $error("normal operation not restored");
   outputs_low_a: assert property (@(posedge clk) disable iff (!resetn)
      force_low |=> !lcd_pclk && !lcd_hsync && !lcd_vsync && !lcd_de && lcd_data == '0)
      else $error("lcd outputs not low in power save");
   display_off_a: assert property (@(posedge clk) disable iff (!resetn)
      psave_en_q |=> !lcd_de)
      else $error("display active in power save");
   mem_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(bvalid_q) && wr_mem_q && $past(mem_block) |-> bresp_q == RESP_SLVERR)
      else $error("memory write accepted in power save");
   lut_access_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(bvalid_q) && wr_lut_q |-> bresp_q == RESP_OKAY)
      else $error("table register refused");
   bypass_lut_a: assert property (@(posedge clk) disable iff (!resetn)
      adv && in_act && depth16_q && !force_low |=> lcd_data == lps_expand565($past(pix_word_q)))
      else $error("16 bpp pixel not bypassing table");
   lut_index_a: assert property (@(posedge clk) disable iff (!resetn)
      adv && in_act && !depth16_q && !force_low |=> lcd_data == $past(ib.lut_pdata))
      else $error("8 bpp pixel not from table");
   clk_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      !pix_run |=> !lcd_pclk ##1 (!lcd_pclk || $past(pix_run)))
      else $error("pixel clock runs while idle");
   enable_reset_a: assert property (@(posedge clk) !resetn |=> !psave_en_q)
      else $error("enable not clear after reset");
endmodule

/* lps_pkg.sv */
package lps_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] PSAVE_CFG_OFS = 12'h0a0;
   localparam logic [11:0] DISP_CFG_OFS = 12'h0a4;
   localparam logic [11:0] LUT_IDX_OFS = 12'h0a8;
   localparam logic [11:0] LUT_DATA_OFS = 12'h0ac;
   localparam int MEM_WIN_BIT = 11;
   localparam int PSAVE_EN_BIT = 0;
   localparam int MEM_PD_BIT = 3;
   localparam int VBLANK_BIT = 7;
   localparam int DEPTH16_BIT = 0;
   localparam int BLANK_BIT = 1;
   localparam logic PSAVE_EN_RST = 1'b0;
   localparam logic MEM_PD_RST = 1'b0;
   localparam logic DEPTH16_RST = 1'b0;
   localparam logic BLANK_RST = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ****************************************
   // look-up table and pixel timing
   // ****************************************
   localparam int LUT_IDX_W = 8;
   localparam int LUT_CH_W = 6;
   localparam int LUT_W = 3 * LUT_CH_W;
   localparam int LUT_ENTRIES = 256;
   localparam int H_ACTIVE = 16;
   localparam int H_TOTAL = 24;
   localparam int V_ACTIVE = 8;
   localparam int V_TOTAL = 12;
   localparam int SEQ_CNT_W = 4;
   localparam logic [3:0] DRAIN_CYC = 4'h4;
   localparam logic [3:0] WAKE_CYC = 4'h4;

   typedef enum logic [2:0] {
      LPS_SEL_PSAVE, LPS_SEL_DISP, LPS_SEL_LIDX, LPS_SEL_LDATA, LPS_SEL_MEM, LPS_SEL_NONE
   } lps_sel_t;

   function automatic lps_sel_t lps_decode(input logic [11:0] addr);
      lps_sel_t sel;
      sel = LPS_SEL_NONE;
      if (addr[MEM_WIN_BIT]) sel = LPS_SEL_MEM;
      else if (addr == PSAVE_CFG_OFS) sel = LPS_SEL_PSAVE;
      else if (addr == DISP_CFG_OFS) sel = LPS_SEL_DISP;
      else if (addr == LUT_IDX_OFS) sel = LPS_SEL_LIDX;
      else if (addr == LUT_DATA_OFS) sel = LPS_SEL_LDATA;
      return sel;
   endfunction

   function automatic logic [31:0] lps_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[8*i +: 8] = new_v[8*i +: 8];
      end
      return res;
   endfunction

   function automatic logic [17:0] lps_expand565(input logic [15:0] px);
      return {px[15:11], px[15], px[10:5], px[4:0], px[4]};
   endfunction

endpackage

/* lps_int_if.sv */
interface lps_int_if;
   import lps_pkg::*;
   logic psave_en;
   logic mem_pd;
   logic lcd_off;
   logic lut_we;
   logic [LUT_IDX_W-1:0] lut_waddr;
   logic [LUT_W-1:0] lut_wdata;
   logic [LUT_IDX_W-1:0] lut_haddr;
   logic [LUT_IDX_W-1:0] lut_paddr;
   logic [LUT_W-1:0] lut_hdata;
   logic [LUT_W-1:0] lut_pdata;
   modport seq (input psave_en, output mem_pd, lcd_off);
   modport seq_user (output psave_en, input mem_pd, lcd_off);
   modport lut (input lut_we, lut_waddr, lut_wdata, lut_haddr, lut_paddr,
                output lut_hdata, lut_pdata);
   modport lut_user (output lut_we, lut_waddr, lut_wdata, lut_haddr, lut_paddr,
                     input lut_hdata, lut_pdata);
endinterface

/* lps_lut_mem.sv */
module lps_lut_mem
   import lps_pkg::*;
#(
   parameter int DEPTH = LUT_ENTRIES
) (
   input wire logic clk,
   input wire logic resetn,
   lps_int_if.lut lb
);
   logic [LUT_W-1:0] mem [DEPTH];
   logic [LUT_W-1:0] hdata_q, hdata_d, pdata_q, pdata_d;

   always_comb begin
      hdata_d = mem[lb.lut_haddr];
      pdata_d = mem[lb.lut_paddr];
   end

   // six bits per primary, 64 levels each
   always_ff @(posedge clk) begin
      if (lb.lut_we) begin
         mem[lb.lut_waddr] <= lb.lut_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         hdata_q <= '0;
         pdata_q <= '0;
      end else begin
         hdata_q <= hdata_d;
         pdata_q <= pdata_d;
      end
   end

   assign lb.lut_hdata = hdata_q;
   assign lb.lut_pdata = pdata_q;
endmodule

/* lps_pwr_seq.sv */
module lps_pwr_seq
   import lps_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   lps_int_if.seq sb
);
   typedef enum logic [3:0] {
      LPS_ST_ACTIVE = 4'b0001,
      LPS_ST_DRAIN = 4'b0010,
      LPS_ST_DOWN = 4'b0100,
      LPS_ST_WAKE = 4'b1000
   } lps_state_t;

   lps_state_t state_q, state_d;
   logic [SEQ_CNT_W-1:0] cnt_q, cnt_d;

   // ****************************************
   // sram interface power-down sequence
   // ****************************************
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         LPS_ST_ACTIVE: begin
            if (sb.psave_en) begin
               state_d = LPS_ST_DRAIN;
               cnt_d = DRAIN_CYC;
            end
         end
         LPS_ST_DRAIN: begin
            if (!sb.psave_en) begin
               state_d = LPS_ST_WAKE;
               cnt_d = WAKE_CYC;
            end else if (cnt_q == '0) begin
               state_d = LPS_ST_DOWN;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         LPS_ST_DOWN: begin
            if (!sb.psave_en) begin
               state_d = LPS_ST_WAKE;
               cnt_d = WAKE_CYC;
            end
         end
         LPS_ST_WAKE: begin
            if (cnt_q == '0) state_d = LPS_ST_ACTIVE;
            else cnt_d = cnt_q - 1'b1;
         end
         default: state_d = LPS_ST_ACTIVE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= LPS_ST_ACTIVE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // status is 1 only while the sram interface is down
   assign sb.mem_pd = (state_q == LPS_ST_DOWN);
   assign sb.lcd_off = (state_q != LPS_ST_ACTIVE);

   reset_status_a: assert property (@(posedge clk) !resetn |=> !sb.mem_pd)
      else $error("status not clear after reset");
   status_down_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(sb.mem_pd) |-> $past(sb.psave_en, 1) && $past(sb.psave_en, 2))
      else $error("status raised without enable");
endmodule

/* lps_panel_model.sv */
module lps_panel_model #(
   parameter int SETTLE = 64
) (
   input wire logic clk,
   input wire logic bias_on,
   input wire logic lcd_pclk,
   input wire logic lcd_hsync,
   input wire logic lcd_vsync,
   input wire logic lcd_de,
   input wire logic [17:0] lcd_data,
   output int act_cnt,
   output int bias_bad
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // panel activity and bias supply watch
   // ****************************************
   int idle;
   int run_cnt;
   int off_cnt = 1000;
   logic bias_q = 1'b0;

   always @(posedge clk) begin
      if (lcd_pclk || lcd_hsync || lcd_vsync || lcd_de || (|lcd_data)) begin
         act_cnt <= act_cnt + 1;
      end
      idle <= lcd_pclk ? 0 : idle + 1;
      run_cnt <= (idle < 2) ? run_cnt + 1 : 0;
      off_cnt <= bias_on ? 0 : off_cnt + 1;
      bias_q <= bias_on;
      // bias may only stand on a running panel
      if (bias_on && idle >= 64) begin
         bias_bad <= bias_bad + 1;
      end
      // signals stop only once the bias has discharged
      if (idle == 2 && (bias_on || off_cnt < SETTLE)) begin
         bias_bad <= bias_bad + 1;
      end
      // bias rises only after the panel has run for the charge time
      if (bias_on && !bias_q && run_cnt < SETTLE) begin
         bias_bad <= bias_bad + 1;
      end
   end
endmodule

/* testbench.sv */
module testbench
   import lps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // signals and instances
   // ****************************************
   logic clk, resetn = 1'h0, bias_on = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic lcd_pclk, lcd_hsync, lcd_vsync, lcd_de;
   logic [17:0] lcd_data;
   int act_cnt, bias_bad, act0, num_errors = 0, check_count = 0;

   lps_top DUT (.*);

   lps_panel_model panel (.clk(clk), .bias_on(bias_on), .lcd_pclk(lcd_pclk),
      .lcd_hsync(lcd_hsync), .lcd_vsync(lcd_vsync), .lcd_de(lcd_de),
      .lcd_data(lcd_data), .act_cnt(act_cnt), .bias_bad(bias_bad));

   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tmo(input bit hit);
      if (hit) begin
         num_errors++;
         $display("ERROR wait expected answer seen none");
         finish_test();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 200);
      s_axi_bready <= 1'h0;
      tmo(n >= 200);
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   task automatic rdr(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 200);
      s_axi_rready <= 1'h0;
      tmo(n >= 200);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask

   task automatic poll(input logic s);
      int n;
      n = 0;
      do begin
         rdr(PSAVE_CFG_OFS);
         n++;
      end while (rd[MEM_PD_BIT] !== s && n < 50);
      tmo(n >= 50);
   endtask

   task automatic px(input logic [17:0] e);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (lcd_vsync !== 1'h1 && n < 2000);
      do begin
         @(posedge clk);
         n++;
      end while (lcd_de !== 1'h1 && n < 4000);
      tmo(n >= 4000);
      chk("lcd_data", {14'h0, e}, {14'h0, lcd_data});
   endtask

   // ****************************************
   // sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'h1;
      rdr(PSAVE_CFG_OFS);
      chk("psave reset", 32'h0, rd & 32'h0000_007f);
      chk("idle lcd", 32'h0, 32'(act_cnt));
      rdr(12'h0f0);
      chk("unmapped", {30'h0, RESP_DECERR}, {30'h0, rs});
      wr(LUT_IDX_OFS, 32'h0000_0005, RESP_OKAY);
      wr(LUT_DATA_OFS, 32'hffff_ffff, RESP_OKAY);
      rdr(LUT_DATA_OFS);
      chk("lut entry", 32'h0003_ffff, rd);
      wr(LUT_DATA_OFS, 32'h0002_1a3c, RESP_OKAY);
      wr(12'h800, 32'h0000_0005, RESP_OKAY);
      wr(DISP_CFG_OFS, 32'h0, RESP_OKAY);
      px(18'h2_1a3c);
      bias_on <= 1'h1;
      wr(DISP_CFG_OFS, 32'h0000_0001, RESP_OKAY);
      px(18'h0_000a);
      bias_on <= 1'h0;
      // bias discharge time before the enable
      repeat (64) @(posedge clk);
      wr(PSAVE_CFG_OFS, 32'h0000_0001, RESP_OKAY);
      // pixel and memory clock sources left running
      poll(1'h1);
      act0 = act_cnt;
      rdr(12'h800);
      chk("mem resp ps", {30'h0, RESP_SLVERR}, {30'h0, rs});
      chk("mem data ps", 32'h0, rd);
      wr(12'h800, 32'h0000_1234, RESP_SLVERR);
      wr(DISP_CFG_OFS, 32'h0000_0001, RESP_OKAY);
      rdr(LUT_DATA_OFS);
      chk("lut ps", 32'h0002_1a3c, rd);
      chk("lcd low ps", 32'(act0), 32'(act_cnt));
      wr(PSAVE_CFG_OFS, 32'h0000_0008, RESP_OKAY);
      poll(1'h0);
      px(18'h0_000a);
      bias_on <= 1'h1;
      rdr(12'h800);
      chk("mem resp", {30'h0, RESP_OKAY}, {30'h0, rs});
      chk("mem data", 32'h0000_0005, rd);
      chk("bias fault", 32'h0, 32'(bias_bad));
      finish_test();
   end
endmodule
